// >>> hw/alarm_latch_clear_manager.sv
// alarm latching and clearing for a servo drive, with its register port
`timescale 1ns/1ns
`include "alarm_defines.svh"

// ********************************
// alarm latch and clear manager
// ********************************
module alarm_latch_clear_manager #(
    parameter int N = `NUM_ALARMS,
    parameter logic [15:0] MIN_REGEN_RES = 16'h000A
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [N-1:0] alarm_raise,
    input wire logic alarm_reset_input,
    input wire logic emergency_stop_input,
    input wire logic servo_on,
    input wire logic motion_forward,
    input wire logic motion_reverse,
    input wire logic power_cycle,
    input wire logic voltage_normal,
    input wire logic temp_normal,
    input wire logic io_connector_unwired,
    input wire logic auto_adjust_done,
    input wire logic param_reset_done,
    input wire logic regen_resistor_fitted,
    output logic [9:0] active_code,
    output logic alarm_active,
    output logic [N-1:0] alarm_latched,
    output logic irq
);

    // ********************************
    // clear class of each alarm
    // ********************************
    function automatic alarm_pkg::clear_class_t class_of(input int idx);
        alarm_pkg::clear_class_t c;
        c = alarm_pkg::CLR_ARST;
        unique case (idx)
            2: c = alarm_pkg::CLR_UV;
            3, 9, 21, 22, 23, 24, 25, 26, 28, 29: c = alarm_pkg::CLR_POWER;
            10: c = alarm_pkg::CLR_ADJUST;
            11: c = alarm_pkg::CLR_ESTOP;
            12: c = alarm_pkg::CLR_REV_LIMIT;
            13: c = alarm_pkg::CLR_FWD_LIMIT;
            15: c = alarm_pkg::CLR_EEPROM;
            31: c = alarm_pkg::CLR_TEMP;
            34: c = alarm_pkg::CLR_FW_UPGRADE;
            35, 36: c = alarm_pkg::CLR_NEVER;
            default: c = alarm_pkg::CLR_ARST;
        endcase
        return c;
    endfunction : class_of

    function automatic logic clear_ok(input alarm_pkg::clear_class_t c,
                                      input alarm_pkg::clear_ctx_t x);
        logic ok;
        ok = 1'b0;
        unique case (c)
            alarm_pkg::CLR_ARST: ok = x.arst_edge;
            alarm_pkg::CLR_POWER: ok = x.power_cycle;
            alarm_pkg::CLR_UV: ok = x.power_cycle || (x.uv_auto && x.voltage_ok);
            alarm_pkg::CLR_ADJUST: ok = x.adjust_ok;
            alarm_pkg::CLR_ESTOP: ok = x.estop_released;
            alarm_pkg::CLR_REV_LIMIT: ok = x.arst_edge || x.servo_off || x.move_fwd;
            alarm_pkg::CLR_FWD_LIMIT: ok = x.arst_edge || x.servo_off || x.move_rev;
            alarm_pkg::CLR_EEPROM: ok = x.eeprom_boot ? x.eeprom_boot_ok : x.arst_edge;
            alarm_pkg::CLR_TEMP: ok = x.temp_ok;
            alarm_pkg::CLR_FW_UPGRADE: ok = x.power_cycle && x.fw_armed;
            alarm_pkg::CLR_NEVER: ok = 1'b0;
        endcase
        return ok;
    endfunction : clear_ok

    // ********************************
    // registers
    // ********************************
    alarm_pkg::bus_req_t bus;
    alarm_pkg::params_t params;
    logic sf_write;
    logic [`IRQ_WIDTH-1:0] irq_events;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    alarm_regs u_regs (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(bus),
        .rd_data(reg_rdata),
        .params(params),
        .sf_write(sf_write),
        .irq_events(irq_events),
        .active_code(active_code),
        .alarm_active(alarm_active),
        .latched(alarm_latched),
        .irq(irq)
    );

    // ********************************
    // input edges and sequence state
    // ********************************
    logic arst_prev_reg;
    logic servo_prev_reg;
    logic startup_reg;
    logic startup_next;
    logic eeprom_boot_reg;
    logic eeprom_boot_next;
    logic param_reset_seen_reg;
    logic param_reset_seen_next;
    logic fw_step1_reg;
    logic fw_step1_next;
    logic fw_armed_reg;
    logic fw_armed_next;
    logic adjust_unwired_reg;
    logic adjust_unwired_next;
    logic [N-1:0] latched_reg;
    logic [N-1:0] latched_next;
    logic [N-1:0] clear_vec;
    logic [N-1:0] raise_vec;
    alarm_pkg::clear_ctx_t ctx;

    wire arst_edge = alarm_reset_input && !arst_prev_reg;
    wire servo_on_edge = servo_on && !servo_prev_reg;
    wire sf_step1 = sf_write && reg_wdata[15:0] == `SF_FW_STEP1;
    wire sf_step2 = sf_write && reg_wdata[15:0] == `SF_FW_STEP2;

    // capacity set while nothing is fitted, or a resistance too low to be real
    wire regen_cap_set = params.regen_capacity != 16'h0000;
    wire regen_bad = regen_cap_set &&
        (!regen_resistor_fitted || params.regen_resistance < MIN_REGEN_RES);

    // 30 then 28, any other value written in between starts over
    assign fw_step1_next = sf_write ? sf_step1 : fw_step1_reg;
    // the arming survives until the power cycle that uses it
    assign fw_armed_next = power_cycle ? 1'b0 :
        ((sf_step2 && fw_step1_reg) || fw_armed_reg);

    // start-up ends at the first servo on after a power cycle
    assign startup_next = power_cycle ? 1'b1 : (servo_on_edge ? 1'b0 : startup_reg);
    assign eeprom_boot_next = (raise_vec[15] && startup_reg) ? 1'b1 :
        (clear_vec[15] ? 1'b0 : eeprom_boot_reg);
    assign param_reset_seen_next = param_reset_done ? 1'b1 :
        (clear_vec[15] ? 1'b0 : param_reset_seen_reg);
    // unwiring must come first; the adjustment done later completes the clear
    assign adjust_unwired_next = io_connector_unwired ? 1'b1 :
        (clear_vec[10] ? 1'b0 : adjust_unwired_reg);

    assign ctx = '{
        arst_edge: arst_edge,
        servo_off: !servo_on,
        move_fwd: motion_forward,
        move_rev: motion_reverse,
        estop_released: !emergency_stop_input,
        power_cycle: power_cycle,
        uv_auto: params.alarm_option[`OPT_UV_AUTO_BIT],
        voltage_ok: voltage_normal,
        adjust_ok: adjust_unwired_reg && auto_adjust_done,
        eeprom_boot_ok: param_reset_seen_reg && servo_on_edge,
        eeprom_boot: eeprom_boot_reg,
        temp_ok: temp_normal,
        fw_armed: fw_armed_reg
    };

    // ********************************
    // latch and clear
    // ********************************
    always_comb begin
        raise_vec = alarm_raise;
        raise_vec[`IDX_ESTOP] = alarm_raise[`IDX_ESTOP] || emergency_stop_input;
        raise_vec[`IDX_REGEN] = alarm_raise[`IDX_REGEN] || regen_bad;
        for (int i = 0; i < N; i++) begin
            clear_vec[i] = clear_ok(class_of(i), ctx);
        end
    end

    // a raise in the clearing cycle keeps the alarm latched
    assign latched_next = (latched_reg & ~clear_vec) | raise_vec;
    assign alarm_latched = latched_reg;
    // one driver for the whole event vector: fatal, cleared, raised
    wire ev_raised = |(raise_vec & ~latched_reg);
    wire ev_cleared = |(latched_reg & ~latched_next);
    wire ev_fatal = |(raise_vec[N-1:N-2] & ~latched_reg[N-1:N-2]);
    assign irq_events = {ev_fatal, ev_cleared, ev_raised};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latched_reg <= '0;
            arst_prev_reg <= 1'b0;
            servo_prev_reg <= 1'b0;
            startup_reg <= 1'b1;
            eeprom_boot_reg <= 1'b0;
            param_reset_seen_reg <= 1'b0;
            fw_step1_reg <= 1'b0;
            fw_armed_reg <= 1'b0;
            adjust_unwired_reg <= 1'b0;
        end else begin
            latched_reg <= latched_next;
            arst_prev_reg <= alarm_reset_input;
            servo_prev_reg <= servo_on;
            startup_reg <= startup_next;
            eeprom_boot_reg <= eeprom_boot_next;
            param_reset_seen_reg <= param_reset_seen_next;
            fw_step1_reg <= fw_step1_next;
            fw_armed_reg <= fw_armed_next;
            adjust_unwired_reg <= adjust_unwired_next;
        end
    end

    // ********************************
    // active alarm presentation
    // ********************************
    alarm_select #(
        .N(N)
    ) u_select (
        .sys_clk(sys_clk),
        .rst(rst),
        .latched(latched_reg),
        .active_code(active_code),
        .alarm_active(alarm_active)
    );

endmodule : alarm_latch_clear_manager

// >>> hw/alarm_defines.svh
// offsets, field positions, reset values and alarm indices of the alarm latch manager
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// ********************************
// register offsets (byte addresses)
// ********************************
`define ADDR_ALARM_OPTION 8'h00
`define ADDR_SPECIAL_FUNC 8'h04
`define ADDR_REGEN_RES 8'h08
`define ADDR_REGEN_CAP 8'h0C
`define ADDR_IRQ_STATUS 8'h10
`define ADDR_IRQ_MASK 8'h14
`define ADDR_ACTIVE_CODE 8'h18
`define ADDR_LATCHED_LO 8'h1C
`define ADDR_LATCHED_HI 8'h20

// ********************************
// fields and reset values
// ********************************
`define OPT_UV_AUTO_BIT 2
`define PARAM_RESET_VALUE 16'h0000
`define MASK_RESET_VALUE 3'h0
`define SF_FW_STEP1 16'h001E
`define SF_FW_STEP2 16'h001C
`define IRQ_RAISED_BIT 0
`define IRQ_CLEARED_BIT 1
`define IRQ_FATAL_BIT 2
`define IRQ_WIDTH 3

// ********************************
// alarm indices
// ********************************
`define NUM_ALARMS 37
`define IDX_ESTOP 11
`define IDX_REGEN 33

`endif

// >>> hw/alarm_pkg.sv
// types shared by the alarm latch manager
package alarm_pkg;

    typedef enum {
        CLR_ARST, CLR_POWER, CLR_UV, CLR_ADJUST, CLR_ESTOP, CLR_REV_LIMIT,
        CLR_FWD_LIMIT, CLR_EEPROM, CLR_TEMP, CLR_FW_UPGRADE, CLR_NEVER
    } clear_class_t;

    typedef struct packed {
        logic arst_edge;
        logic servo_off;
        logic move_fwd;
        logic move_rev;
        logic estop_released;
        logic power_cycle;
        logic uv_auto;
        logic voltage_ok;
        logic adjust_ok;
        logic eeprom_boot_ok;
        logic eeprom_boot;
        logic temp_ok;
        logic fw_armed;
    } clear_ctx_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [15:0] alarm_option;
        logic [15:0] special_function;
        logic [15:0] regen_resistance;
        logic [15:0] regen_capacity;
    } params_t;

endpackage : alarm_pkg

// >>> hw/alarm_select.sv
// picks the active alarm code out of the latched alarm vector
`timescale 1ns/1ns
`include "alarm_defines.svh"

module alarm_select #(
    parameter int N = `NUM_ALARMS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [N-1:0] latched,
    output logic [9:0] active_code,
    output logic alarm_active
);

    // ********************************
    // code table
    // ********************************
    function automatic logic [9:0] code_of(input int idx);
        logic [9:0] t [0:36];
        t = '{10'd1, 10'd2, 10'd3, 10'd4, 10'd5, 10'd6, 10'd7, 10'd8, 10'd9, 10'd11,
              10'd12, 10'd13, 10'd14, 10'd15, 10'd16, 10'd17, 10'd18, 10'd19, 10'd20,
              10'd22, 10'd23, 10'd24, 10'd25, 10'd26, 10'd27, 10'd28, 10'd29, 10'd30,
              10'd31, 10'd35, 10'd48, 10'd67, 10'd83, 10'd85, 10'd99, 10'd555, 10'd880};
        return t[idx];
    endfunction : code_of

    // ********************************
    // priority: lowest index wins
    // ********************************
    logic [9:0] pick_next;

    always_comb begin
        pick_next = 10'h000;
        for (int i = N - 1; i >= 0; i--) begin
            if (latched[i]) begin
                pick_next = code_of(i);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            active_code <= 10'h000;
            alarm_active <= 1'b0;
        end else begin
            active_code <= pick_next;
            alarm_active <= |latched;
        end
    end

endmodule : alarm_select

// >>> hw/alarm_regs.sv
// register file: parameters, interrupt status and mask, alarm state readback
`timescale 1ns/1ns
`include "alarm_defines.svh"

module alarm_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input alarm_pkg::bus_req_t bus,
    output logic [31:0] rd_data,
    output alarm_pkg::params_t params,
    output logic sf_write,
    input wire logic [`IRQ_WIDTH-1:0] irq_events,
    input wire logic [9:0] active_code,
    input wire logic alarm_active,
    input wire logic [`NUM_ALARMS-1:0] latched,
    output logic irq
);

    // ********************************
    // decode
    // ********************************
    logic [`IRQ_WIDTH-1:0] status_reg;
    logic [`IRQ_WIDTH-1:0] mask_reg;
    logic [63:0] latched_wide;
    logic [31:0] rd_next;
    wire wr_opt = bus.wr && bus.addr == `ADDR_ALARM_OPTION;
    wire wr_sf = bus.wr && bus.addr == `ADDR_SPECIAL_FUNC;
    wire wr_res = bus.wr && bus.addr == `ADDR_REGEN_RES;
    wire wr_cap = bus.wr && bus.addr == `ADDR_REGEN_CAP;
    wire wr_stat = bus.wr && bus.addr == `ADDR_IRQ_STATUS;
    wire wr_mask = bus.wr && bus.addr == `ADDR_IRQ_MASK;
    // set wins over a write-one-to-clear in the same cycle
    wire [`IRQ_WIDTH-1:0] status_next =
        (status_reg & ~(wr_stat ? bus.wdata[`IRQ_WIDTH-1:0] : '0)) | irq_events;

    assign latched_wide = {{(64 - `NUM_ALARMS){1'b0}}, latched};
    assign irq = |(status_reg & mask_reg);
    assign sf_write = wr_sf;

    always_comb begin
        unique case (bus.addr)
            `ADDR_ALARM_OPTION: rd_next = {16'h0000, params.alarm_option};
            `ADDR_SPECIAL_FUNC: rd_next = {16'h0000, params.special_function};
            `ADDR_REGEN_RES: rd_next = {16'h0000, params.regen_resistance};
            `ADDR_REGEN_CAP: rd_next = {16'h0000, params.regen_capacity};
            `ADDR_IRQ_STATUS: rd_next = {29'h0, status_reg};
            `ADDR_IRQ_MASK: rd_next = {29'h0, mask_reg};
            `ADDR_ACTIVE_CODE: rd_next = {21'h0, alarm_active, active_code};
            `ADDR_LATCHED_LO: rd_next = latched_wide[31:0];
            `ADDR_LATCHED_HI: rd_next = latched_wide[63:32];
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // ********************************
    // storage
    // ********************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            params <= {4{`PARAM_RESET_VALUE}};
            status_reg <= '0;
            mask_reg <= `MASK_RESET_VALUE;
            rd_data <= 32'h0000_0000;
        end else begin
            if (wr_opt) params.alarm_option <= bus.wdata[15:0];
            if (wr_sf) params.special_function <= bus.wdata[15:0];
            if (wr_res) params.regen_resistance <= bus.wdata[15:0];
            if (wr_cap) params.regen_capacity <= bus.wdata[15:0];
            if (wr_mask) mask_reg <= bus.wdata[`IRQ_WIDTH-1:0];
            status_reg <= status_next;
            rd_data <= bus.rd ? rd_next : 32'h0000_0000;
        end
    end

endmodule : alarm_regs

// >>> testbench/alarm_lcm_sva.sv
// concurrent checks on the alarm latch manager ports
`timescale 1ns/1ns
`include "alarm_defines.svh"

module alarm_lcm_sva #(
    parameter int N = `NUM_ALARMS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [N-1:0] alarm_raise,
    input wire logic alarm_reset_input,
    input wire logic emergency_stop_input,
    input wire logic servo_on,
    input wire logic power_cycle,
    input wire logic voltage_normal,
    input wire logic temp_normal,
    input wire logic auto_adjust_done,
    input wire logic [9:0] active_code,
    input wire logic alarm_active,
    input wire logic [N-1:0] alarm_latched
);
    // ********************************
    // latch and clear relations
    // ********************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    raise_latch_a: assert property (alarm_raise[0] |=> alarm_latched[0])
        else $error("raised alarm not latched");
    code_shown_a: assert property (alarm_latched[0] |=> active_code == 10'h001 && alarm_active)
        else $error("active code not lowest latched");
    reset_clear_a: assert property ($rose(alarm_reset_input) && !alarm_raise[0]
        |=> !alarm_latched[0])
        else $error("alarm reset did not clear");
    uv_hold_a: assert property (alarm_latched[2] && !power_cycle && !voltage_normal
        |=> alarm_latched[2])
        else $error("under-voltage cleared early");
    power_hold_a: assert property (alarm_latched[9] && !power_cycle |=> alarm_latched[9])
        else $error("power-class alarm cleared early");
    adjust_hold_a: assert property (alarm_latched[10] && !auto_adjust_done
        |=> alarm_latched[10])
        else $error("adjustment alarm cleared early");
    stop_clear_a: assert property (alarm_latched[11] && !emergency_stop_input
        && !alarm_raise[11] |=> !alarm_latched[11])
        else $error("stop alarm not self cleared");
    limit_soff_a: assert property (alarm_latched[12] && !servo_on && !alarm_raise[12]
        |=> !alarm_latched[12])
        else $error("servo off did not clear limit");
    temp_clear_a: assert property (alarm_latched[31] && temp_normal && !alarm_raise[31]
        |=> !alarm_latched[31])
        else $error("temperature warning stuck");
    fatal_hold_a: assert property (alarm_latched[35] |=> alarm_latched[35])
        else $error("processor failure cleared");
endmodule : alarm_lcm_sva

bind alarm_latch_clear_manager alarm_lcm_sva #(.N(N)) u_alarm_lcm_sva (.sys_clk, .rst,
    .alarm_raise, .alarm_reset_input, .emergency_stop_input, .servo_on, .power_cycle,
    .voltage_normal, .temp_normal, .auto_adjust_done, .active_code, .alarm_active,
    .alarm_latched);

// >>> testbench/di_model.sv
// machine controller model driving the drive digital inputs
`timescale 1ns/1ns

module di_model (
    input wire logic sys_clk,
    output logic alarm_reset_input,
    output logic emergency_stop_input,
    output logic servo_on,
    output logic motion_forward,
    output logic motion_reverse,
    output logic io_connector_unwired,
    output logic param_reset_done
);
    // ********************************
    // input levels and actions
    // ********************************
    initial begin
        {alarm_reset_input, emergency_stop_input, motion_forward} = '0;
        {motion_reverse, io_connector_unwired, param_reset_done} = '0;
        servo_on = 1'b1;
    end
    // one cycle: 0 reset, 1 servo off, 2 forward, 3 reverse; 4 stop release stays released
    task automatic apply(input int op);
        case (op)
            0: alarm_reset_input <= 1'b1;
            1: servo_on <= 1'b0;
            2: motion_forward <= 1'b1;
            3: motion_reverse <= 1'b1;
            default: emergency_stop_input <= 1'b0;
        endcase
        @(posedge sys_clk);
        {alarm_reset_input, motion_forward, motion_reverse} <= '0;
        // only the servo off action restores servo on, so start-up sequences keep it low
        if (op == 1) servo_on <= 1'b1;
    endtask : apply
    // levels: 0 stop input, 1 servo on, 2 connector unwired
    task automatic set_level(input int which, input logic lvl);
        case (which)
            0: emergency_stop_input <= lvl;
            1: servo_on <= lvl;
            default: io_connector_unwired <= lvl;
        endcase
    endtask : set_level
    task automatic param_reset;
        param_reset_done <= 1'b1;
        @(posedge sys_clk);
        param_reset_done <= 1'b0;
    endtask : param_reset
endmodule : di_model

// >>> testbench/alarm_latch_clear_manager_tb.sv
// self-checking bench of the alarm latch and clear manager
`timescale 1ns/1ns
`include "alarm_defines.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module alarm_latch_clear_manager_tb;
    localparam int N = `NUM_ALARMS;
    localparam logic [N-1:0] bit0_vec = 1;
    typedef struct packed {
        logic [5:0] idx;
        logic [3:0] act;
        logic keep;
    } row_t;
    logic sys_clk, rst, reg_wr, reg_rd, power_cycle, voltage_normal, temp_normal;
    logic auto_adjust_done, regen_resistor_fitted, alarm_reset_input, emergency_stop_input;
    logic servo_on, motion_forward, motion_reverse, io_connector_unwired, param_reset_done;
    logic alarm_active, irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [N-1:0] alarm_raise, alarm_latched;
    logic [9:0] active_code;
    int miscompares = 0;
    int cmp_count = 0;
    // act: 0 reset 1 servo off 2 fwd 3 rev 4 stop release 5 power 6 voltage 7 temp 8 adjust
    row_t rows [18] = '{'{6'd0, 4'd0, 1'b0}, '{6'd5, 4'd0, 1'b0}, '{6'd33, 4'd0, 1'b0},
        '{6'd3, 4'd0, 1'b1}, '{6'd3, 4'd5, 1'b0}, '{6'd29, 4'd0, 1'b1}, '{6'd29, 4'd5, 1'b0},
        '{6'd9, 4'd0, 1'b1}, '{6'd2, 4'd0, 1'b1}, '{6'd2, 4'd6, 1'b1}, '{6'd2, 4'd5, 1'b0},
        '{6'd12, 4'd1, 1'b0}, '{6'd12, 4'd2, 1'b0}, '{6'd13, 4'd3, 1'b0},
        '{6'd13, 4'd2, 1'b1}, '{6'd11, 4'd4, 1'b0}, '{6'd31, 4'd7, 1'b0},
        '{6'd36, 4'd5, 1'b1}};

    alarm_latch_clear_manager #(.N(N), .MIN_REGEN_RES(16'h000A)) u_alarm_latch_clear_manager (
        .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alarm_raise,
        .alarm_reset_input, .emergency_stop_input, .servo_on, .motion_forward,
        .motion_reverse, .power_cycle, .voltage_normal, .temp_normal, .io_connector_unwired,
        .auto_adjust_done, .param_reset_done, .regen_resistor_fitted, .active_code,
        .alarm_active, .alarm_latched, .irq);
    di_model u_di_model (.sys_clk, .alarm_reset_input, .emergency_stop_input, .servo_on,
        .motion_forward, .motion_reverse, .io_connector_unwired, .param_reset_done);

    // ********************************
    // drivers
    // ********************************
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // trailing idle cycle keeps back to back calls from assigning a strobe twice
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        @(posedge sys_clk);
    endtask : reg_read
    task automatic raise_vec(input logic [N-1:0] v);
        alarm_raise <= v;
        @(posedge sys_clk);
        alarm_raise <= '0;
        tick(2);
    endtask : raise_vec
    task automatic apply_act(input int act);
        if (act < 5) begin
            u_di_model.apply(act);
        end else begin
            power_cycle <= (act == 5);
            voltage_normal <= (act == 6);
            temp_normal <= (act == 7);
            auto_adjust_done <= (act == 8);
            @(posedge sys_clk);
            {power_cycle, voltage_normal, temp_normal, auto_adjust_done} <= '0;
        end
    endtask : apply_act
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        tick(20000);
        miscompares++;
        stop_test();
    end

    // ********************************
    // scenarios
    // ********************************
    initial begin
        {rst, reg_wr, reg_rd, power_cycle, voltage_normal, temp_normal} = 6'h3F & 6'h20;
        {auto_adjust_done, regen_resistor_fitted} = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        alarm_raise = '0;
        tick(8);
        rst <= 1'b0;
        tick(1);
        `CHK("reset latched", {N{1'b0}}, alarm_latched)
        foreach (rows[i]) begin
            if (rows[i].act == 4) u_di_model.set_level(0, 1'b1);
            raise_vec(bit0_vec << rows[i].idx);
            `CHK("raised", 1'b1, alarm_latched[rows[i].idx])
            apply_act(rows[i].act);
            tick(2);
            `CHK("after clear", rows[i].keep, alarm_latched[rows[i].idx])
            apply_act(5);
            apply_act(0);
            tick(2);
        end
        reg_write(`ADDR_IRQ_MASK, 32'h1);
        raise_vec(bit0_vec);
        `CHK("irq raised", 1'b1, irq)
        reg_read(`ADDR_IRQ_STATUS);
        `CHK("status", 1'b1, rd_val[`IRQ_RAISED_BIT])
        reg_write(`ADDR_IRQ_STATUS, 32'h7);
        `CHK("irq cleared", 1'b0, irq)
        raise_vec(bit0_vec << 35);
        `CHK("code lowest", 10'h001, active_code)
        apply_act(0);
        tick(2);
        `CHK("code fatal", 10'h22B, active_code)
        `CHK("active flag", 1'b1, alarm_active)
        reg_read(`ADDR_ACTIVE_CODE);
        `CHK("code reg", 32'h0000_062B, rd_val)
        reg_read(`ADDR_LATCHED_HI);
        `CHK("latched hi", 32'h0000_0018, rd_val)
        reg_read(`ADDR_IRQ_STATUS);
        `CHK("status all", 3'h7, rd_val[2:0])
        reg_write(`ADDR_ALARM_OPTION, 32'h4);
        raise_vec(bit0_vec << 2);
        apply_act(6);
        tick(2);
        `CHK("uv auto", 1'b0, alarm_latched[2])
        reg_write(`ADDR_ALARM_OPTION, 32'h0);
        raise_vec(bit0_vec << 34);
        reg_write(`ADDR_SPECIAL_FUNC, {16'h0000, `SF_FW_STEP2});
        reg_write(`ADDR_SPECIAL_FUNC, {16'h0000, `SF_FW_STEP1});
        apply_act(5);
        tick(2);
        `CHK("fw wrong order", 1'b1, alarm_latched[34])
        reg_write(`ADDR_SPECIAL_FUNC, {16'h0000, `SF_FW_STEP1});
        reg_write(`ADDR_SPECIAL_FUNC, {16'h0000, `SF_FW_STEP2});
        apply_act(5);
        tick(2);
        `CHK("fw cleared", 1'b0, alarm_latched[34])
        raise_vec(bit0_vec << 10);
        apply_act(8);
        tick(2);
        `CHK("adjust wired", 1'b1, alarm_latched[10])
        u_di_model.set_level(2, 1'b1);
        tick(1);
        apply_act(8);
        tick(2);
        `CHK("adjust done", 1'b0, alarm_latched[10])
        u_di_model.set_level(2, 1'b0);
        u_di_model.set_level(1, 1'b0);
        apply_act(5);
        raise_vec(bit0_vec << 15);
        apply_act(0);
        tick(2);
        `CHK("eeprom boot", 1'b1, alarm_latched[15])
        u_di_model.param_reset();
        u_di_model.set_level(1, 1'b1);
        tick(2);
        `CHK("eeprom servo on", 1'b0, alarm_latched[15])
        raise_vec(bit0_vec << 15);
        apply_act(0);
        tick(2);
        `CHK("eeprom running", 1'b0, alarm_latched[15])
        reg_write(`ADDR_REGEN_CAP, 32'h5);
        tick(2);
        `CHK("regen unfitted", 1'b1, alarm_latched[`IDX_REGEN])
        regen_resistor_fitted <= 1'b1;
        reg_write(`ADDR_REGEN_RES, 32'h9);
        apply_act(0);
        tick(2);
        `CHK("regen low res", 1'b1, alarm_latched[`IDX_REGEN])
        reg_write(`ADDR_REGEN_RES, 32'hA);
        apply_act(0);
        tick(2);
        `CHK("regen ok", 1'b0, alarm_latched[`IDX_REGEN])
        reg_write(`ADDR_REGEN_CAP, 32'h0);
        reg_read(8'h40);
        `CHK("unmapped", 32'h0, rd_val)
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        `CHK("rst fatal", {N{1'b0}}, alarm_latched)
        `CHK("rst code", 10'h000, active_code)
        reg_read(`ADDR_IRQ_MASK);
        `CHK("rst mask", 32'h0, rd_val)
        stop_test();
    end
endmodule : alarm_latch_clear_manager_tb
